// ---- verilog/utc_pkg.sv ----
// constants and types for the uart transmit control block
package utc_pkg;
    localparam int CLOCK_HZ = 20_000_000;
    localparam int BAUD_HZ  = 115_200;
    // bit time in cycles, rounded down
    localparam int BIT_CYCLES = CLOCK_HZ / BAUD_HZ;
    localparam logic [7:0] BIT_CYC = 8'(BIT_CYCLES - 1);

    localparam logic [3:0] STA_OFS  = 4'h0;
    localparam logic [3:0] TXD_OFS  = 4'h4;
    localparam logic [3:0] MODE_OFS = 4'h8;

    localparam int ISEL1_BIT = 15;
    localparam int INV_BIT   = 14;
    localparam int ISEL0_BIT = 13;
    localparam int BRK_BIT   = 11;
    localparam int EN_BIT    = 10;
    localparam int FULL_BIT  = 9;
    localparam int TRMT_BIT  = 8;
    localparam int INFRARED_ENCODE_ON_BIT  = 0;
    localparam logic [15:0] STA_RESET = 16'h0100;

    localparam logic [1:0] IRQ_XFER  = 2'h0;
    localparam logic [1:0] IRQ_DONE  = 2'h1;
    localparam logic [1:0] IRQ_EMPTY = 2'h2;

    localparam int DATA_W = 8;
    localparam int DEPTH  = 4;
    localparam int PTR_W  = 2;
    localparam int CNT_W  = 3;
    localparam logic [CNT_W-1:0] FULL_CNT = 3'h4;

    localparam int SHIFT_W = 14;
    localparam logic [3:0] DATA_FRAME_BITS  = 4'hA;
    localparam logic [3:0] BREAK_FRAME_BITS = 4'hE;
    // start bit, twelve zeros, stop bit
    localparam logic [SHIFT_W-1:0] BREAK_FRAME = 14'h2000;

    typedef enum logic {ST_IDLE, ST_SHIFT} utc_tx_state_type;
endpackage

// ---- verilog/utc_buf_if.sv ----
// link between the transmit control and its character buffer
`timescale 1ns/1ns
`default_nettype none
interface utc_buf_if;
    logic                        push;
    logic [utc_pkg::DATA_W-1:0]  push_data;
    logic                        pop;
    logic                        flush;
    logic [utc_pkg::DATA_W-1:0]  head;
    logic                        full;
    logic                        empty;
    logic [utc_pkg::CNT_W-1:0]   count;
    modport ctrl  (output push, push_data, pop, flush, input head, full, empty, count);
    modport store (input push, push_data, pop, flush, output head, full, empty, count);
endinterface
`default_nettype wire

// ---- verilog/utc_tx_buffer.sv ----
// four-character transmit buffer with registered head word
`timescale 1ns/1ns
`default_nettype none
module utc_tx_buffer (
    input  wire logic  clock,
    input  wire logic  sys_rst,
    utc_buf_if.store   bus
);
    typedef struct packed {
        logic [utc_pkg::DEPTH-1:0][utc_pkg::DATA_W-1:0] mem;
        logic [utc_pkg::PTR_W-1:0]                      wr;
        logic [utc_pkg::PTR_W-1:0]                      rd;
        logic [utc_pkg::CNT_W-1:0]                      cnt;
        logic [utc_pkg::DATA_W-1:0]                     head;
    } utc_buf_state_type;

    utc_buf_state_type q, d;

    always_comb begin
        d = q;
        if (bus.flush) begin
            d.wr  = '0;
            d.rd  = '0;
            d.cnt = '0;
        end else begin
            if (bus.push && q.cnt != utc_pkg::FULL_CNT) begin
                d.mem[q.wr] = bus.push_data;
                d.wr        = q.wr + 2'h1;
                d.cnt       = d.cnt + 3'h1;
            end
            if (bus.pop && q.cnt != '0) begin
                d.rd  = q.rd + 2'h1;
                d.cnt = d.cnt - 3'h1;
            end
        end
        // head follows the next read slot, including a same-cycle write
        d.head = d.mem[d.rd];
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.head  = q.head;
    assign bus.full  = (q.cnt == utc_pkg::FULL_CNT);
    assign bus.empty = (q.cnt == '0);
    assign bus.count = q.cnt;
endmodule // utc_tx_buffer
`default_nettype wire

// ---- verilog/utc_tx_control.sv ----
// uart transmit control: status/control register, shifter, pin ownership
// Function
// - In one interrupt mode the interrupt fires when a character enters the shifter and empties the buffer.
// - With selection 01 the interrupt fires when the last frame, a character or a break, has left the shifter with the buffer empty.
// - Without infrared encoding, polarity 1 makes the line idle low and 0 idle high.
// - A break request sends a start bit, twelve zero bits and a stop bit as the next frame.
// - The break request clears itself when the break frame has finished.
// - While transmit is enabled the port owns and drives the transmit pin.
// - Clearing the enable aborts the frame, resets the buffer and gives the pin back.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module utc_tx_control (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic [3:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    input  wire logic [3:0]   avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    input  wire logic         port_pin_data,
    output logic              serial_tx_pin,
    output logic              tx_pin_owned,
    output logic              tx_irq
);
    typedef struct packed {
        logic                           ack;
        logic [31:0]                    rdata;
        logic                           isel1;
        logic                           inv;
        logic                           isel0;
        logic                           brk;
        logic                           en;
        logic                           infrared_encode_on;
        utc_pkg::utc_tx_state_type      st;
        logic [utc_pkg::SHIFT_W-1:0]    shreg;
        logic [3:0]                     bits_left;
        logic [7:0]                     baud;
        logic                           is_brk;
        logic                           irq;
        logic                           pin;
    } utc_ctl_state_type;

    utc_ctl_state_type q, d;
    utc_buf_if buf_bus ();

    utc_tx_buffer u_buffer (
        .clock   (clock),
        .sys_rst (sys_rst),
        .bus     (buf_bus)
    );

    logic        req;
    logic        hit_sta;
    logic        hit_txd;
    logic        hit_mode;
    logic        stall;
    logic        wr;
    logic        wr_sta;
    logic        pop_evt;
    logic        frame_end;
    logic        done_evt;
    logic        empty_evt;
    logic        line_raw;
    logic [15:0] sta_word;

    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction

    always_comb begin
        d         = q;
        d.irq     = 1'b0;
        hit_sta   = 1'b0;
        hit_txd   = 1'b0;
        hit_mode  = 1'b0;
        pop_evt   = 1'b0;
        frame_end = 1'b0;
        line_raw  = 1'b1;
        req       = avs_read || avs_write;
        if (addr_is(avs_address, utc_pkg::STA_OFS)) begin
            hit_sta = 1'b1;
        end else if (addr_is(avs_address, utc_pkg::TXD_OFS)) begin
            hit_txd = 1'b1;
        end else if (addr_is(avs_address, utc_pkg::MODE_OFS)) begin
            hit_mode = 1'b1;
        end
        // data write into a full buffer waits for room
        stall  = avs_write && hit_txd && avs_byteenable[0] && q.en && buf_bus.full;
        wr     = q.ack && avs_write;
        wr_sta = wr && hit_sta && avs_byteenable[1];

        sta_word = '0;
        sta_word[utc_pkg::ISEL1_BIT] = q.isel1;
        sta_word[utc_pkg::INV_BIT]   = q.inv;
        sta_word[utc_pkg::ISEL0_BIT] = q.isel0;
        sta_word[utc_pkg::BRK_BIT]   = q.brk;
        sta_word[utc_pkg::EN_BIT]    = q.en;
        sta_word[utc_pkg::FULL_BIT]  = buf_bus.full;
        sta_word[utc_pkg::TRMT_BIT]  = (q.st == utc_pkg::ST_IDLE) && buf_bus.empty;

        // bus answer: one wait cycle, then completion; a stalled data write waits until the stall clears
        d.ack = req && !q.ack && !stall;
        if (req && !q.ack) begin
            d.rdata = '0;
            if (avs_read && hit_sta) begin
                d.rdata[15:0] = sta_word;
            end else if (avs_read && hit_mode) begin
                d.rdata[utc_pkg::INFRARED_ENCODE_ON_BIT] = q.infrared_encode_on;
            end
        end

        // shifter; a disabled port drops everything
        if (!q.en) begin
            d.st     = utc_pkg::ST_IDLE;
            d.is_brk = 1'b0;
        end else begin
            case (q.st)
                utc_pkg::ST_IDLE: begin
                    if (q.brk) begin
                        d.shreg     = utc_pkg::BREAK_FRAME;
                        d.bits_left = utc_pkg::BREAK_FRAME_BITS;
                        d.is_brk    = 1'b1;
                        d.baud      = utc_pkg::BIT_CYC;
                        d.st        = utc_pkg::ST_SHIFT;
                    end else if (!buf_bus.empty) begin
                        d.shreg     = {5'h1F, buf_bus.head, 1'b0};
                        d.bits_left = utc_pkg::DATA_FRAME_BITS;
                        d.is_brk    = 1'b0;
                        d.baud      = utc_pkg::BIT_CYC;
                        d.st        = utc_pkg::ST_SHIFT;
                        pop_evt     = 1'b1;
                    end
                end
                utc_pkg::ST_SHIFT: begin
                    line_raw = q.shreg[0];
                    if (q.baud == '0) begin
                        d.baud      = utc_pkg::BIT_CYC;
                        d.shreg     = {1'b1, q.shreg[utc_pkg::SHIFT_W-1:1]};
                        d.bits_left = q.bits_left - 4'h1;
                        if (q.bits_left == 4'h1) begin
                            frame_end = 1'b1;
                            d.st      = utc_pkg::ST_IDLE;
                            if (q.is_brk) begin
                                d.brk = 1'b0;
                            end
                        end
                    end else begin
                        d.baud = q.baud - 8'h01;
                    end
                end
                default: d.st = utc_pkg::ST_IDLE;
            endcase
        end

        empty_evt = pop_evt && buf_bus.count == 3'h1;
        done_evt  = frame_end && buf_bus.empty && !d.brk;
        case ({q.isel1, q.isel0})
            utc_pkg::IRQ_DONE:  d.irq = done_evt;
            utc_pkg::IRQ_EMPTY: d.irq = empty_evt;
            default:            d.irq = pop_evt;
        endcase

        // software writes after hardware, so a set wins over the clear
        if (wr_sta) begin
            d.isel1 = avs_writedata[utc_pkg::ISEL1_BIT];
            d.inv   = avs_writedata[utc_pkg::INV_BIT];
            d.isel0 = avs_writedata[utc_pkg::ISEL0_BIT];
            d.brk   = avs_writedata[utc_pkg::BRK_BIT];
            d.en    = avs_writedata[utc_pkg::EN_BIT];
        end
        if (wr && hit_mode && avs_byteenable[0]) begin
            d.infrared_encode_on = avs_writedata[utc_pkg::INFRARED_ENCODE_ON_BIT];
        end

        if (d.en) begin
            d.pin = ((d.st == utc_pkg::ST_SHIFT) ? d.shreg[0] : 1'b1) ^ (d.inv && !d.infrared_encode_on);
        end else begin
            d.pin = port_pin_data;
        end
    end

    assign buf_bus.push      = wr && hit_txd && avs_byteenable[0] && q.en;
    assign buf_bus.push_data = avs_writedata[7:0];
    assign buf_bus.pop       = pop_evt;
    assign buf_bus.flush     = !q.en;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q       <= '0;
            q.pin   <= 1'b0;
            q.baud  <= '0;
            q.shreg <= '1;
        end else begin
            q <= d;
        end
    end

    assign avs_waitrequest = req && !q.ack;
    assign avs_readdata    = q.rdata;
    assign serial_tx_pin   = q.pin;
    assign tx_pin_owned    = q.en;
    assign tx_irq          = q.irq;

    default clocking dc @(posedge clock); endclocking
    default disable iff (sys_rst);

    irq_on_empty_a: assert property (({q.isel1, q.isel0} == utc_pkg::IRQ_EMPTY && empty_evt) |=> tx_irq)
        else $error("no interrupt when buffer emptied");
    irq_empty_only_a: assert property (({q.isel1, q.isel0} == utc_pkg::IRQ_EMPTY && pop_evt
        && buf_bus.count > 3'h1) |=> !tx_irq)
        else $error("interrupt while buffer still held data");
    irq_on_done_a: assert property (({q.isel1, q.isel0} == utc_pkg::IRQ_DONE && tx_irq
        && $past({q.isel1, q.isel0}) == utc_pkg::IRQ_DONE) |-> $past(frame_end))
        else $error("done interrupt without finished frame");
    irq_on_xfer_a: assert property (({q.isel1, q.isel0} == utc_pkg::IRQ_XFER && pop_evt) |=> tx_irq)
        else $error("no interrupt on transfer to shifter");
    idle_level_a: assert property ((q.en && !q.infrared_encode_on && q.st == utc_pkg::ST_IDLE) |-> serial_tx_pin == !q.inv)
        else $error("idle level does not follow polarity");
    break_len_a: assert property ((q.en && q.st == utc_pkg::ST_IDLE && q.brk && !wr_sta)
        |=> (q.is_brk && q.bits_left == utc_pkg::BREAK_FRAME_BITS))
        else $error("break frame not started with fourteen bits");
    break_low_a: assert property ((q.en && q.st == utc_pkg::ST_SHIFT && q.is_brk && q.bits_left > 4'h1)
        |-> serial_tx_pin == (q.inv && !q.infrared_encode_on))
        else $error("break frame line not at space level");
    break_clear_a: assert property ((frame_end && q.is_brk && !wr_sta) |=> !q.brk)
        else $error("break request not cleared after break");
    pin_own_a: assert property ((!q.en && !$past(sys_rst)) |-> serial_tx_pin == $past(port_pin_data))
        else $error("disabled port still drives the pin");
    abort_a: assert property (!q.en |=> (q.st == utc_pkg::ST_IDLE && buf_bus.count == '0))
        else $error("disable did not abort and flush");
    bus_stall_a: assert property ((stall && !q.ack) |-> avs_waitrequest)
        else $error("full buffer write not stalled");

    break_sent_c: cover property (frame_end && q.is_brk);
    done_irq_c: cover property ({q.isel1, q.isel0} == utc_pkg::IRQ_DONE && tx_irq);
    full_stall_c: cover property (stall);
    disable_abort_c: cover property (q.st == utc_pkg::ST_SHIFT && !q.en);
endmodule // utc_tx_control
`default_nettype wire

// ---- verif/utc_rx_model.sv ----
// remote serial receiver watching the transmit line
`timescale 1ns/1ns
`default_nettype none
module utc_rx_model (
    input  wire logic  clock,
    input  wire logic  sys_rst,
    input  wire logic  line,
    input  wire logic  listen,
    output logic [7:0] rx_data,
    output logic [3:0] rx_bits,
    output int         rx_count
);
    localparam int BT = utc_pkg::BIT_CYCLES;
    logic       busy;
    int         tick;
    logic [3:0] idx;
    logic [7:0] sh;
    // bit index of the first high sample after bit 8 marks the stop bit
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst || !listen) begin
            busy <= 1'b0;
            idx <= 4'h0;
            if (sys_rst) begin
                rx_count <= 0;
                rx_bits <= 4'h0;
            end
        end else if (!busy) begin
            busy <= !line;
            tick <= 0;
            idx <= 4'h0;
        end else begin
            tick <= tick + 1;
            if (tick == BT / 2 + int'(idx) * BT) begin
                idx <= idx + 4'h1;
                if (idx >= 4'h1 && idx <= 4'h8) sh <= {line, sh[7:1]};
                if (idx >= 4'h9 && line) begin
                    rx_data <= sh;
                    rx_bits <= idx;
                    rx_count <= rx_count + 1;
                    busy <= 1'b0;
                end else if (idx == 4'hF) busy <= 1'b0;
            end
        end
    end
endmodule // utc_rx_model
`default_nettype wire

// ---- verif/uart_transmit_control_tb_top.sv ----
// self-checking bench for the uart transmit control
`timescale 1ns/1ns
`default_nettype none
module uart_transmit_control_tb_top;
    typedef struct {logic inv; logic infrared_encode_on; logic [1:0] isel; int n_irq; int first;} utc_row_type;
    logic        clock, sys_rst, avs_read, avs_write, port_pin_data, listen, flip;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic        avs_waitrequest, serial_tx_pin, tx_pin_owned, tx_irq;
    logic [7:0]  rx_data, d0;
    logic [3:0]  rx_bits;
    int          rx_count, fails, check_count, irq_n, irq_rx, base;
    utc_row_type rows [3] = '{'{1'b0, 1'b0, 2'h0, 4, 0}, '{1'b1, 1'b0, 2'h1, 1, 4}, '{1'b1, 1'b1, 2'h2, 2, 0}};
    utc_tx_control utc_tx_control_i (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_pin_data(port_pin_data), .serial_tx_pin(serial_tx_pin), .tx_pin_owned(tx_pin_owned),
        .tx_irq(tx_irq));
    utc_rx_model utc_rx_model_i (.clock(clock), .sys_rst(sys_rst), .line(serial_tx_pin ^ flip),
        .listen(listen), .rx_data(rx_data), .rx_bits(rx_bits), .rx_count(rx_count));
    always #25 clock = !clock;
    always @(posedge clock) begin
        if (tx_irq === 1'b1) begin
            if (irq_n == 0) irq_rx = rx_count;
            irq_n++;
        end
    end
    task automatic close_out;
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error %0t %s", $time, msg);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
        int n;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20000);
        r = avs_readdata;
        if (n >= 20000) begin
            chk(1'b0, "bus timeout");
            close_out();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, utc_pkg::STA_OFS, 32'h0, d);
            n++;
        end while (d[utc_pkg::TRMT_BIT] !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            chk(1'b0, "idle timeout");
            close_out();
        end
    endtask
    function automatic logic [31:0] sta(logic [1:0] s, logic v, logic b, logic e);
        sta = 32'h0;
        sta[utc_pkg::ISEL1_BIT] = s[1];
        sta[utc_pkg::ISEL0_BIT] = s[0];
        sta[utc_pkg::INV_BIT] = v;
        sta[utc_pkg::BRK_BIT] = b;
        sta[utc_pkg::EN_BIT] = e;
    endfunction
    initial begin
        {clock, avs_read, avs_write, listen, flip, fails, check_count, irq_n} = '0;
        {avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        port_pin_data = 1'b1;
        sys_rst = 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        chk(tx_pin_owned === 1'b0 && serial_tx_pin === 1'b1, "pin after reset");
        bus(1'b0, utc_pkg::STA_OFS, 32'h0, d);
        chk(d[15:0] === utc_pkg::STA_RESET, "status reset value");
        bus(1'b0, 4'hC, 32'h0, d);
        chk(d === 32'h0, "unmapped read");
        for (int i = 0; i < 3; i++) begin
            listen <= 1'b0;
            wr(utc_pkg::MODE_OFS, 32'(rows[i].infrared_encode_on) << utc_pkg::INFRARED_ENCODE_ON_BIT);
            wr(utc_pkg::STA_OFS, sta(rows[i].isel, rows[i].inv, 1'b0, 1'b1));
            repeat (3) @(posedge clock);
            chk(serial_tx_pin === !(rows[i].inv && !rows[i].infrared_encode_on) && tx_pin_owned === 1'b1, "idle");
            flip <= rows[i].inv && !rows[i].infrared_encode_on;
            listen <= 1'b1;
            base = rx_count;
            irq_n = 0;
            d0 = 8'h30 + 8'(i * 4);
            for (int k = 0; k < 4; k++) begin
                wr(utc_pkg::TXD_OFS, 32'(d0 + 8'(k)));
                if (k == 0) repeat (10) @(posedge clock);
            end
            wait_idle();
            repeat (10) @(posedge clock);
            chk(rx_count - base == 4 && rx_data === d0 + 8'h3 && rx_bits === 4'h9, "frames");
            chk(irq_n == rows[i].n_irq && irq_rx - base == rows[i].first, "irq");
        end
        listen <= 1'b0;
        wr(utc_pkg::MODE_OFS, 32'h0);
        wr(utc_pkg::STA_OFS, sta(2'h0, 1'b0, 1'b0, 1'b1));
        flip <= 1'b0;
        repeat (3) @(posedge clock);
        listen <= 1'b1;
        base = rx_count;
        wr(utc_pkg::STA_OFS, sta(2'h0, 1'b0, 1'b1, 1'b1));
        wait_idle();
        repeat (10) @(posedge clock);
        chk(rx_count - base == 1 && rx_bits === 4'hD, "break frame");
        bus(1'b0, utc_pkg::STA_OFS, 32'h0, d);
        chk(d[utc_pkg::BRK_BIT] === 1'b0, "break bit cleared");
        wr(utc_pkg::TXD_OFS, 32'h55);
        repeat (300) @(posedge clock);
        listen <= 1'b0;
        wr(utc_pkg::TXD_OFS, 32'h66);
        wr(utc_pkg::TXD_OFS, 32'h77);
        wr(utc_pkg::STA_OFS, sta(2'h0, 1'b0, 1'b0, 1'b0));
        port_pin_data <= 1'b0;
        repeat (3) @(posedge clock);
        chk(tx_pin_owned === 1'b0 && serial_tx_pin === 1'b0, "pin back to port");
        port_pin_data <= 1'b1;
        wr(utc_pkg::STA_OFS, sta(2'h0, 1'b0, 1'b0, 1'b1));
        bus(1'b0, utc_pkg::STA_OFS, 32'h0, d);
        chk(d[utc_pkg::TRMT_BIT] === 1'b1 && serial_tx_pin === 1'b1, "abort and flush");
        base = rx_count;
        listen <= 1'b1;
        repeat (4000) @(posedge clock);
        chk(rx_count == base, "flushed buffer sent nothing");
        close_out();
    end
endmodule // uart_transmit_control_tb_top
`default_nettype wire
